// ==== rtl/dbdac_host.v ====
// Notes on behaviour
// - chip select goes low before the write strobe for every write and rises after it.
// - byte mode drives upper-byte select high for the first pass and low for the second, steady within each.
// - full width: twelve-bit code on bus bits 0 to 11, bit 11 MSB.
// - eight-bit bus (DATA_W of 8): bit 7 the MSB of the low byte, bit 3 the MSB of the zero-extended upper byte.
// - code is straight binary, zero lowest, all ones full scale.
`include "dbdac_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module dbdac_host #(
   parameter DATA_W = 12,
   parameter SETUP_CYC = `DBDAC_SETUP_CYC,
   parameter STROBE_CYC = `DBDAC_STROBE_CYC,
   parameter HOLD_CYC = `DBDAC_HOLD_CYC
) (
   // clock and reset
   input wire core_clk,
   input wire reset,
   // software port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output wire [31:0] rdata,
   // converter pins
   output reg chip_sel_n,
   output reg write_n,
   output reg [DATA_W-1:0] data_bus,
   output reg upper_byte_sel,
   output reg load_output_n,
   output reg async_clear_n,
   output reg sleep_n
);
   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_SETUP = 5'b00010;
   localparam [4:0] ST_STROBE = 5'b00100;
   localparam [4:0] ST_HOLD = 5'b01000;
   localparam [4:0] ST_PULSE = 5'b10000;
   localparam [1:0] K_WRITE = 2'd0;
   localparam [1:0] K_LOAD = 2'd1;
   localparam [1:0] K_CLEAR = 2'd2;

   wire [2:0] ctrl;
   wire [11:0] code;
   wire [2:0] cmd;
   wire tmr_done;
   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [1:0] kind_q;
   reg [1:0] kind_d;
   reg hi_pass_q;
   reg hi_pass_d;
   reg [11:0] shadow_q;
   reg [11:0] shadow_d;
   reg [11:0] last_q;
   reg [11:0] last_d;
   reg tmr_load;
   reg [3:0] tmr_val;
   // full-width lanes pass the code as is; byte lanes steer one byte per pass
   wire [11:0] bus_next = (DATA_W >= 12) ? shadow_d : {4'h0, lane(shadow_d, hi_pass_d)};

   // byte lane selector: the upper byte carries bits 11..8, zero extended
   function [7:0] lane;
      input [11:0] value;
      input upper;
      begin
         lane = upper ? {4'h0, value[11:8]} : value[7:0];
      end
   endfunction

   dbdac_regs u_regs (
      .core_clk(core_clk),
      .reset(reset),
      .addr(addr),
      .wdata(wdata),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .rdata(rdata),
      .ctrl_q(ctrl),
      .code_q(code),
      .cmd_pulse(cmd),
      .busy(state_q != ST_IDLE),
      .last_code(last_q)
   );

   dbdac_timer #(.WIDTH(4)) u_timer (
      .core_clk(core_clk),
      .reset(reset),
      .load(tmr_load),
      .value(tmr_val),
      .done(tmr_done)
   );

   always @* begin
      state_d = state_q;
      kind_d = kind_q;
      hi_pass_d = hi_pass_q;
      shadow_d = shadow_q;
      last_d = last_q;
      tmr_load = 1'b0;
      tmr_val = 4'h0;
      case (state_q)
         ST_IDLE: begin
            // clear outranks write and load; commands while busy are dropped
            if (cmd[`DBDAC_CMD_CLEAR]) begin
               kind_d = K_CLEAR;
               state_d = ST_PULSE;
               tmr_load = 1'b1;
               tmr_val = STROBE_CYC[3:0];
            end else if (cmd[`DBDAC_CMD_WRITE]) begin
               kind_d = K_WRITE;
               shadow_d = code;
               hi_pass_d = ctrl[`DBDAC_CTRL_BYTEMODE];
               state_d = ST_SETUP;
               tmr_load = 1'b1;
               tmr_val = SETUP_CYC[3:0];
            end else if (cmd[`DBDAC_CMD_LOAD]) begin
               kind_d = K_LOAD;
               state_d = ST_PULSE;
               tmr_load = 1'b1;
               tmr_val = STROBE_CYC[3:0];
            end
         end
         ST_SETUP: begin
            if (tmr_done) begin
               state_d = ST_STROBE;
               tmr_load = 1'b1;
               tmr_val = STROBE_CYC[3:0];
            end
         end
         ST_STROBE: begin
            if (tmr_done) begin
               state_d = ST_HOLD;
               tmr_load = 1'b1;
               tmr_val = HOLD_CYC[3:0];
            end
         end
         ST_HOLD: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (hi_pass_q) begin
                  // second byte pass for the low byte
                  hi_pass_d = 1'b0;
                  state_d = ST_SETUP;
                  tmr_val = SETUP_CYC[3:0];
               end else if (ctrl[`DBDAC_CTRL_AUTOLOAD]) begin
                  last_d = shadow_q;
                  kind_d = K_LOAD;
                  state_d = ST_PULSE;
                  tmr_val = STROBE_CYC[3:0];
               end else begin
                  last_d = shadow_q;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_PULSE: begin
            if (tmr_done) begin
               if (kind_q == K_CLEAR) begin
                  last_d = 12'h000;
               end
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         kind_q <= K_WRITE;
         hi_pass_q <= 1'b0;
         shadow_q <= 12'h000;
         last_q <= 12'h000;
         chip_sel_n <= 1'b1;
         write_n <= 1'b1;
         data_bus <= {DATA_W{1'b0}};
         upper_byte_sel <= 1'b0;
         load_output_n <= 1'b1;
         async_clear_n <= 1'b1;
         sleep_n <= 1'b1;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         hi_pass_q <= hi_pass_d;
         shadow_q <= shadow_d;
         last_q <= last_d;
         sleep_n <= ~ctrl[`DBDAC_CTRL_SLEEP];
         // select with strobe; select spans setup to hold so write rises inside it
         chip_sel_n <= ~(state_d == ST_SETUP || state_d == ST_STROBE || state_d == ST_HOLD);
         // write rises while select still low
         write_n <= ~(state_d == ST_STROBE);
         // byte select steady over each pass; in byte mode it drops between the two passes while select stays low
         upper_byte_sel <= hi_pass_d;
         // straight binary, msb at the top bit
         data_bus <= bus_next[DATA_W-1:0];
         load_output_n <= ~(state_d == ST_PULSE && kind_d == K_LOAD);
         async_clear_n <= ~(state_d == ST_PULSE && kind_d == K_CLEAR);
      end
   end
endmodule
`default_nettype wire

// ==== rtl/dbdac_consts.vh ====
`ifndef DBDAC_CONSTS_VH
`define DBDAC_CONSTS_VH
// software register offsets (byte addresses, one word each)
`define DBDAC_REG_CTRL 8'h00
`define DBDAC_REG_CODE 8'h04
`define DBDAC_REG_CMD 8'h08
`define DBDAC_REG_STATUS 8'h0C
`define DBDAC_REG_LAST 8'h10
// control register fields
`define DBDAC_CTRL_SLEEP 0
`define DBDAC_CTRL_BYTEMODE 1
`define DBDAC_CTRL_AUTOLOAD 2
`define DBDAC_CTRL_RESET 3'h0
// command register fields (write one to start)
`define DBDAC_CMD_WRITE 0
`define DBDAC_CMD_LOAD 1
`define DBDAC_CMD_CLEAR 2
// status register fields
`define DBDAC_STAT_BUSY 0
`define DBDAC_STAT_SLEEP 1
// pin timing in ns and cycles at 50 MHz (20 ns period), each rounded up
`define DBDAC_CLK_NS 20
`define DBDAC_SETUP_NS 20
`define DBDAC_STROBE_NS 40
`define DBDAC_HOLD_NS 20
`define DBDAC_CYC(ns) (((ns) + `DBDAC_CLK_NS - 1) / `DBDAC_CLK_NS)
`define DBDAC_SETUP_CYC `DBDAC_CYC(`DBDAC_SETUP_NS)
`define DBDAC_STROBE_CYC `DBDAC_CYC(`DBDAC_STROBE_NS)
`define DBDAC_HOLD_CYC `DBDAC_CYC(`DBDAC_HOLD_NS)
`endif

// ==== rtl/dbdac_timer.v ====
`timescale 1ns/100ps
`default_nettype none
// loadable down counter; done is high while the count is zero
module dbdac_timer #(
   parameter WIDTH = 4
) (
   // clock and reset
   input wire core_clk,
   input wire reset,
   // control
   input wire load,
   input wire [WIDTH-1:0] value,
   output wire done
);
   reg [WIDTH-1:0] count_q;
   always @(posedge core_clk) begin
      if (reset) begin
         count_q <= {WIDTH{1'b0}};
      end else if (load) begin
         count_q <= value;
      end else if (count_q != {WIDTH{1'b0}}) begin
         count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   assign done = (count_q == {WIDTH{1'b0}});
endmodule
`default_nettype wire

// ==== rtl/dbdac_regs.v ====
`include "dbdac_consts.vh"
`timescale 1ns/100ps
`default_nettype none
// software-side register slave; read data registered, one cycle after the strobe
module dbdac_regs (
   // clock and reset
   input wire core_clk,
   input wire reset,
   // software port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [31:0] rdata,
   // towards the sequencer
   output reg [2:0] ctrl_q,
   output reg [11:0] code_q,
   output wire [2:0] cmd_pulse,
   // from the sequencer
   input wire busy,
   input wire [11:0] last_code
);
   assign cmd_pulse = (wr_en && addr == `DBDAC_REG_CMD) ? wdata[2:0] : 3'h0;
   always @(posedge core_clk) begin
      if (reset) begin
         ctrl_q <= `DBDAC_CTRL_RESET;
         code_q <= 12'h000;
         rdata <= 32'h0000_0000;
      end else begin
         if (wr_en && addr == `DBDAC_REG_CTRL) begin
            ctrl_q <= wdata[2:0];
         end
         if (wr_en && addr == `DBDAC_REG_CODE) begin
            code_q <= wdata[11:0];
         end
         rdata <= 32'h0000_0000;
         if (rd_en) begin
            case (addr)
               `DBDAC_REG_CTRL: rdata <= {29'h0, ctrl_q};
               `DBDAC_REG_CODE: rdata <= {20'h0, code_q};
               `DBDAC_REG_STATUS: rdata <= {30'h0, ~ctrl_q[`DBDAC_CTRL_SLEEP] ? 1'b0 : 1'b1, busy};
               `DBDAC_REG_LAST: rdata <= {20'h0, last_code};
               default: rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/dbdac_host_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module dbdac_chk #(
   parameter DATA_W = 12
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // software port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rdata,
   // converter pins
   input wire logic chip_sel_n,
   input wire logic write_n,
   input wire logic [DATA_W-1:0] data_bus,
   input wire logic load_output_n,
   input wire logic async_clear_n,
   input wire logic sleep_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   a_write_in_sel: assert property (!write_n |-> !chip_sel_n)
      else $error("write strobe outside select");
   a_pass_shape: assert property ($fell(chip_sel_n) |-> write_n [*2] ##1 !write_n [*3] ##1 write_n [*2] ##1 chip_sel_n)
      else $error("write pass has wrong shape");
   a_bus_held: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(data_bus))
      else $error("bus moved during select");
   a_load_pulse: assert property ($fell(load_output_n) |-> !load_output_n [*3] ##1 load_output_n)
      else $error("load pulse wrong length");
   a_clear_pulse: assert property ($fell(async_clear_n) |-> !async_clear_n [*3] ##1 async_clear_n)
      else $error("clear pulse wrong length");
   a_load_apart: assert property (!chip_sel_n |-> load_output_n && async_clear_n)
      else $error("load or clear during pass");
   a_sleep_on: assert property (wr_en && addr == 8'h00 && wdata[0] |-> ##[1:2] !sleep_n)
      else $error("sleep pin not entered");
   a_sleep_off: assert property (wr_en && addr == 8'h00 && !wdata[0] |-> ##[1:2] sleep_n)
      else $error("sleep pin not left");
   a_rdata_quiet: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
      else $error("read data outside read cycle");
endmodule
bind dbdac_host dbdac_chk #(.DATA_W(DATA_W)) i_chk (.core_clk(core_clk), .reset(reset), .addr(addr),
   .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .chip_sel_n(chip_sel_n), .write_n(write_n),
   .data_bus(data_bus), .load_output_n(load_output_n), .async_clear_n(async_clear_n), .sleep_n(sleep_n));
`default_nettype wire

// ==== tb/dbdac_dev.sv ====
`timescale 1ns/100ps
`default_nettype none
module dbdac_dev (
   // converter pins
   input wire logic chip_sel_n,
   input wire logic write_n,
   input wire logic [11:0] data_bus,
   input wire logic load_output_n,
   input wire logic async_clear_n,
   input wire logic sleep_n,
   // device state
   output logic [11:0] in_q,
   output logic [11:0] dac_q,
   output wire logic powered_down
);
   // power-on contents are zero
   initial in_q = 12'h000;
   initial dac_q = 12'h000;
   always @(posedge write_n or negedge async_clear_n) begin
      if (!async_clear_n) in_q <= 12'h000;
      else if (!chip_sel_n) in_q <= data_bus;
   end
   always @(negedge load_output_n or negedge async_clear_n) begin
      if (!async_clear_n) dac_q <= 12'h000;
      else dac_q <= in_q;
   end
   assign powered_down = !sleep_n;
endmodule
`default_nettype wire

// ==== tb/tb_double_buffered_dac_parallel_input.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_double_buffered_dac_parallel_input;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   wire [31:0] rdata;
   wire chip_sel_n, write_n, upper_byte_sel, load_output_n, async_clear_n, sleep_n, powered_down;
   wire [11:0] data_bus, in_q, dac_q;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   initial forever #10 core_clk = ~core_clk;
   dbdac_host i_dut (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .chip_sel_n(chip_sel_n), .write_n(write_n), .data_bus(data_bus),
      .upper_byte_sel(upper_byte_sel), .load_output_n(load_output_n), .async_clear_n(async_clear_n),
      .sleep_n(sleep_n));
   dbdac_dev i_dev (.chip_sel_n(chip_sel_n), .write_n(write_n), .data_bus(data_bus),
      .load_output_n(load_output_n), .async_clear_n(async_clear_n), .sleep_n(sleep_n), .in_q(in_q),
      .dac_q(dac_q), .powered_down(powered_down));
   task test_done();
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
      @(posedge core_clk) wr_en <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk) begin addr <= a; rd_en <= 1'b1; end
      @(posedge core_clk) rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   // bounded poll on the busy flag
   task idle();
      logic [31:0] s;
      for (int i = 0; i < 20; i++) begin
         rd(8'h0C, s);
         if (s[0] === 1'b0) break;
      end
   endtask
   task t_write_load();
      logic [31:0] v;
      chk({chip_sel_n, write_n, upper_byte_sel, load_output_n, async_clear_n, sleep_n}, 32'h0000_0037);
      wr(8'h04, 32'h0000_0A5C);
      wr(8'h08, 32'h0000_0001);
      // the load command lands while busy and must be dropped
      wr(8'h08, 32'h0000_0002);
      idle();
      chk(in_q, 32'h0000_0A5C);
      chk(dac_q, 32'h0000_0000);
      wr(8'h08, 32'h0000_0002);
      idle();
      chk(dac_q, 32'h0000_0A5C);
      rd(8'h10, v);
      chk(v, 32'h0000_0A5C);
   endtask
   task t_full_scale();
      wr(8'h00, 32'h0000_0004);
      wr(8'h04, 32'h0000_0FFF);
      wr(8'h08, 32'h0000_0001);
      idle();
      // the three-cycle autoload pulse falls inside the busy flag; the extra wait is margin
      repeat (4) @(posedge core_clk);
      chk(dac_q, 32'h0000_0FFF);
      wr(8'h00, 32'h0000_0000);
   endtask
   task t_clear();
      logic [31:0] v;
      wr(8'h08, 32'h0000_0004);
      idle();
      chk({in_q, dac_q}, 32'h0000_0000);
      rd(8'h10, v);
      chk(v, 32'h0000_0000);
      rd(8'h20, v);
      chk(v, 32'h0000_0000);
   endtask
   task t_sleep();
      logic [31:0] v;
      wr(8'h00, 32'h0000_0001);
      rd(8'h0C, v);
      chk({v[1], powered_down}, 32'h0000_0003);
      wr(8'h00, 32'h0000_0000);
      rd(8'h0C, v);
      chk({v[1], powered_down}, 32'h0000_0000);
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      t_write_load();
      t_full_scale();
      t_clear();
      t_sleep();
      test_done();
   end
endmodule
`default_nettype wire
